// ==== common/cwgsd_pkg.sv ====
// shared constants for the complementary wave shutdown block
package cwgsd_pkg;

  localparam int unsigned DB_W          = 6;        // width of each dead-band counter
  localparam int unsigned SRC_N         = 4;        // number of selectable input sources
  localparam int unsigned SRC_SEL_W     = 2;        // width of the source select

  // override level codes, applied while shut down
  typedef logic [1:0] cwgsd_ovr_t;
  localparam cwgsd_ovr_t OVR_LOW        = 2'h0;     // drive low
  localparam cwgsd_ovr_t OVR_HIGH       = 2'h1;     // drive high
  localparam cwgsd_ovr_t OVR_HIZ        = 2'h2;     // release the pin
  localparam cwgsd_ovr_t OVR_SPARE      = 2'h3;     // treated as drive low

  // dead-band clock selection
  localparam logic       CLK_FAST       = 1'b0;     // fast internal oscillator, tick every cycle
  localparam logic       CLK_DIV        = 1'b1;     // divided clock, tick every DIV_CYC cycles

  localparam int unsigned DIV_CYC       = 4;        // divider ratio for the slow selection
  localparam int unsigned DIV_W         = 3;        // width of the divider counter

  localparam int unsigned ACT_WIN       = 255;      // cycles without an edge before source counts idle
  localparam int unsigned ACT_W         = 8;        // width of the activity counter

  // reset values
  localparam logic [DB_W-1:0] DB_RST    = 6'h00;    // dead-band counter after reset
  localparam logic       FLAG_RST       = 1'b0;     // shutdown event flag after reset

endpackage : cwgsd_pkg

// ==== common/cwgsd_db_if.sv ====
// carrier between the shutdown control and the dead-band generator
`timescale 1ns/1ps
interface cwgsd_db_if;
  import cwgsd_pkg::*;

  logic            tick;       // dead-band clock enable
  logic            src;        // selected source level
  logic [DB_W-1:0] rise_dly;   // rising-edge delay in ticks
  logic [DB_W-1:0] fall_dly;   // falling-edge delay in ticks
  logic            wave_a;     // primary output before polarity
  logic            wave_b;     // complementary output before polarity

  modport ctl (output tick, output src, output rise_dly, output fall_dly, input wave_a, input wave_b);
  modport db  (input tick, input src, input rise_dly, input fall_dly, output wave_a, output wave_b);

endinterface : cwgsd_db_if

// ==== logic/cwgsd_deadband.sv ====
// dead-band generator: two complementary waves with independent edge delays
`timescale 1ns/1ps
module cwgsd_deadband
  import cwgsd_pkg::*;
(
  input  wire logic      clk_i,   // system clock
  input  wire logic      rst_i,   // asynchronous reset, active high
  cwgsd_db_if.db         bus      // tick, source and delays in, waves out
);

  logic [1:0]           target;   // wanted level per channel
  logic [1:0]           wave_r;   // delayed level per channel
  logic [1:0]           prev_r;   // wanted level at the previous tick
  logic [DB_W-1:0]      cnt_r [2];// remaining delay per channel
  logic [DB_W-1:0]      dly [2];  // reload value per channel

  // channel 0 follows the source, channel 1 its complement
  assign target[0] = bus.src;
  assign target[1] = ~bus.src;
  assign dly[0]    = bus.rise_dly;
  assign dly[1]    = bus.fall_dly;

  // one independent counter per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    // reload on each transition, delay only the asserting edge
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_r[ch]  <= DB_RST;
        wave_r[ch] <= 1'b0;
        prev_r[ch] <= 1'b0;
      end else if (bus.tick) begin
        prev_r[ch] <= target[ch];
        if (target[ch] != prev_r[ch]) begin
          cnt_r[ch] <= dly[ch];
        end
        if (!target[ch]) begin
          // deasserting edge passes straight through
          wave_r[ch] <= 1'b0;
        end else if (target[ch] != prev_r[ch]) begin
          // first tick of the new level only loads the counter
          wave_r[ch] <= 1'b0;
        end else if (!wave_r[ch]) begin
          if (cnt_r[ch] == DB_RST) begin
            wave_r[ch] <= 1'b1;
          end else begin
            cnt_r[ch] <= cnt_r[ch] - 6'h01;
          end
        end
      end
    end
  end

  // waves never overlap since each waits on its own delay
  assign bus.wave_a = wave_r[0];
  assign bus.wave_b = wave_r[1];

endmodule : cwgsd_deadband

// ==== logic/cwgsd_top.sv ====
// complementary wave generator with dead band and auto-shutdown
//
// Contract
// - two complementary outputs with dead band
// - two independent 6-bit edge delay counters
// - software event bit forces shutdown and overrides
// - no auto-restart: shutdown holds while bit set
// - auto-restart: clear bit, resume on rising edge
// - enabled fault input forces override levels
// - logic cell and fault pin ORed
// - one select bit per fault source
// - level faults block clearing unless disabled
// - runs on own clock, keeps running asleep
// - fast oscillator kept on when selected, enabled and source active
`timescale 1ns/1ps
module cwgsd_top
  import cwgsd_pkg::*;
#(
  parameter int unsigned DIV    = DIV_CYC,   // cycles per tick of the slow selection
  parameter int unsigned WINDOW = ACT_WIN    // idle cycles before source counts inactive
) (
  input  wire logic                   clk_i,                // system clock, 100 MHz
  input  wire logic                   rst_i,                // asynchronous reset, active high
  input  wire logic                   enable_i,             // generator enable
  input  wire logic [SRC_N-1:0]       src_i,                // candidate input sources
  input  wire logic [SRC_SEL_W-1:0]   src_sel_i,            // which source drives the wave
  input  wire logic                   clk_sel_i,            // dead-band clock selection
  input  wire logic [DB_W-1:0]        rise_dly_i,           // rising-edge dead band
  input  wire logic [DB_W-1:0]        fall_dly_i,           // falling-edge dead band
  input  wire logic                   pol_a_i,              // invert primary output
  input  wire logic                   pol_b_i,              // invert complementary output
  input  wire logic                   oe_a_i,               // primary pin output enable
  input  wire logic                   oe_b_i,               // complementary pin output enable
  input  wire cwgsd_pkg::cwgsd_ovr_t  ovr_a_i,              // primary override level
  input  wire cwgsd_pkg::cwgsd_ovr_t  ovr_b_i,              // complementary override level
  input  wire logic                   asd_en_i,             // auto-shutdown function enable
  input  wire logic                   auto_restart_i,       // auto-restart enable
  input  wire logic                   event_set_i,          // software writes one to event bit
  input  wire logic                   event_clr_i,          // software writes zero to event bit
  input  wire logic                   fault_source0_select_i, // enable logic cell source
  input  wire logic                   fault_source1_select_i, // enable fault pin source
  input  wire logic                   logic_cell_output_i,  // fault from logic cell
  input  wire logic                   fault_pin_input_i,    // fault from external pin
  output logic                        out_a_o,              // primary pin level
  output logic                        out_a_oe_o,           // primary pin driven
  output logic                        out_b_o,              // complementary pin level
  output logic                        out_b_oe_o,           // complementary pin driven
  output logic                        shutdown_event_flag_o,// event bit readback
  output logic                        shutdown_o,           // shutdown state active
  output logic                        fast_osc_keep_o       // keep fast oscillator on in sleep
);

  typedef enum logic {
    CWGSD_RUN,
    CWGSD_SHUT
  } cwgsd_state_t;

  cwgsd_db_if dbi ();                         // carrier to the dead-band generator

  cwgsd_state_t     state_r;                  // shutdown state machine
  cwgsd_state_t     state_nxt;                // its next value
  logic             flag_r;                   // shutdown event bit
  logic             flag_nxt;                 // its next value
  logic [DIV_W-1:0] div_r;                    // clock divider
  logic             tick;                     // dead-band clock enable
  logic             src_sel;                  // selected source level
  logic             src_prev_r;               // source one cycle back
  logic             src_rise;                 // rising edge of the source
  logic [ACT_W-1:0] act_r;                    // cycles since the last source edge
  logic             src_active;               // source has toggled recently
  logic             ext_fault;                // any enabled external fault
  logic             restart;                  // auto-restart resumes this cycle
  logic             shut_now;                 // shutdown in force this cycle

  // select one source by index
  function automatic logic pick_src(input logic [SRC_N-1:0] v, input logic [SRC_SEL_W-1:0] s);
    pick_src = v[s];
  endfunction : pick_src

  // override code to pin level; spare code drives low
  function automatic logic ovr_level(input cwgsd_ovr_t c);
    ovr_level = (c == OVR_HIGH);
  endfunction : ovr_level

  // override code to pin enable; only the release code floats
  function automatic logic ovr_drive(input cwgsd_ovr_t c);
    ovr_drive = (c != OVR_HIZ);
  endfunction : ovr_drive

  assign src_sel = pick_src(src_i, src_sel_i);

  // dead-band clock divider; one clock only, the slow rate is an enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else if (!enable_i || clk_sel_i == CLK_FAST) begin
      div_r <= '0;
    end else if (div_r == DIV_W'(DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // ticks come from the block's own selection, never from a cpu clock gate,
  // so nothing here stops when the core goes to sleep
  assign tick = enable_i && (clk_sel_i == CLK_FAST || div_r == DIV_W'(DIV - 1));

  // source edge detection for the restart condition
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_sel;
    end
  end

  assign src_rise = src_sel && !src_prev_r;

  // activity window: an idle source lets the fast oscillator stop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_r <= ACT_W'(WINDOW);
    end else if (src_sel != src_prev_r) begin
      act_r <= '0;
    end else if (act_r != ACT_W'(WINDOW)) begin
      act_r <= act_r + 8'h01;
    end
  end

  assign src_active = (act_r != ACT_W'(WINDOW));

  // each source gated by its own select, then ORed
  assign ext_fault = asd_en_i &&
                     ((fault_source0_select_i && logic_cell_output_i) ||
                      (fault_source1_select_i && fault_pin_input_i));

  // restart only once the cause is gone and the source rises
  assign restart = auto_restart_i && asd_en_i && !ext_fault && !event_set_i && src_rise;

  // event bit: hardware set wins over any clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (event_set_i || ext_fault) begin
      flag_nxt = 1'b1;
    end else if (!asd_en_i) begin
      // disabling auto-shutdown drops a held fault state
      flag_nxt = 1'b0;
    end else if (state_r == CWGSD_SHUT && restart) begin
      flag_nxt = 1'b0;
    end else if (event_clr_i && !auto_restart_i) begin
      // software clear only counts while no fault level is present
      flag_nxt = 1'b0;
    end else if (event_clr_i && state_r == CWGSD_RUN) begin
      // with auto-restart a clear before shutdown is taken as written
      flag_nxt = 1'b0;
    end
  end

  // event bit register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // shutdown state transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CWGSD_RUN: begin
        if (flag_nxt) begin
          state_nxt = CWGSD_SHUT;
        end
      end
      CWGSD_SHUT: begin
        if (ext_fault) begin
          // level sensitive: stay while the input is high
          state_nxt = CWGSD_SHUT;
        end else if (auto_restart_i && asd_en_i) begin
          // wait for the next rising edge of the source
          if (restart) begin
            state_nxt = CWGSD_RUN;
          end
        end else if (!flag_nxt) begin
          // manual mode leaves only once the bit is cleared
          state_nxt = CWGSD_RUN;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CWGSD_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs are registered, so a fault reaches the pins at the next edge;
  // that one cycle is the price of glitch-free flip-flop outputs
  assign shut_now = (state_nxt == CWGSD_SHUT);

  // dead-band generator hookup
  assign dbi.tick     = tick;
  assign dbi.src      = src_sel;
  assign dbi.rise_dly = rise_dly_i;
  assign dbi.fall_dly = fall_dly_i;

  cwgsd_deadband u_db (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (dbi.db)
  );

  // primary pin: low and released while disabled, else override while shut down, else wave with polarity
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_a_o    <= 1'b0;
      out_a_oe_o <= 1'b0;
    end else if (!enable_i) begin
      out_a_o    <= 1'b0;
      out_a_oe_o <= 1'b0;
    end else if (shut_now) begin
      out_a_o    <= ovr_level(ovr_a_i);
      out_a_oe_o <= ovr_drive(ovr_a_i);
    end else begin
      out_a_o    <= dbi.wave_a ^ pol_a_i;
      out_a_oe_o <= oe_a_i;
    end
  end

  // complementary pin: same scheme with its own settings
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_b_o    <= 1'b0;
      out_b_oe_o <= 1'b0;
    end else if (!enable_i) begin
      out_b_o    <= 1'b0;
      out_b_oe_o <= 1'b0;
    end else if (shut_now) begin
      out_b_o    <= ovr_level(ovr_b_i);
      out_b_oe_o <= ovr_drive(ovr_b_i);
    end else begin
      out_b_o    <= dbi.wave_b ^ pol_b_i;
      out_b_oe_o <= oe_b_i;
    end
  end

  // status readback
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shutdown_event_flag_o <= FLAG_RST;
      shutdown_o            <= 1'b0;
    end else begin
      shutdown_event_flag_o <= flag_nxt;
      shutdown_o            <= shut_now;
    end
  end

  // oscillator request, independent of whatever clocks the core
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_osc_keep_o <= 1'b0;
    end else begin
      fast_osc_keep_o <= enable_i && src_active && (clk_sel_i == CLK_FAST);
    end
  end

endmodule : cwgsd_top

// ==== verif/cwgsd_top_asserts.sv ====
// port-level checks for the wave shutdown block
`timescale 1ns/1ps
module cwgsd_top_asserts
  import cwgsd_pkg::*;
(
  input wire logic                  clk_i,                  // clock
  input wire logic                  rst_i,                  // reset
  input wire logic                  enable_i,               // enable
  input wire logic [SRC_N-1:0]      src_i,                  // sources
  input wire logic [SRC_SEL_W-1:0]  src_sel_i,              // source pick
  input wire logic                  clk_sel_i,              // tick pick
  input wire logic                  pol_b_i,                // b invert
  input wire logic                  oe_b_i,                 // b enable
  input wire cwgsd_pkg::cwgsd_ovr_t ovr_a_i,                // a override
  input wire logic                  asd_en_i,               // shutdown on
  input wire logic                  auto_restart_i,         // auto restart
  input wire logic                  event_set_i,            // set pulse
  input wire logic                  event_clr_i,            // clear pulse
  input wire logic                  fault_source0_select_i, // cell pick
  input wire logic                  fault_source1_select_i, // pin pick
  input wire logic                  logic_cell_output_i,    // cell fault
  input wire logic                  fault_pin_input_i,      // pin fault
  input wire logic                  out_a_o,                // a level
  input wire logic                  out_a_oe_o,             // a driven
  input wire logic                  out_b_o,                // b level
  input wire logic                  shutdown_event_flag_o,  // event bit
  input wire logic                  shutdown_o,             // shut state
  input wire logic                  fast_osc_keep_o         // osc kept
);
  logic flt; // any enabled fault level
  logic sel; // selected source level
  assign flt = (fault_source0_select_i & logic_cell_output_i) | (fault_source1_select_i & fault_pin_input_i);
  assign sel = src_i[src_sel_i];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sw_shut_a: assert property (enable_i && asd_en_i && event_set_i |=> shutdown_o && shutdown_event_flag_o)
    else $error("event set did not shut down");
  fault_shut_a: assert property (enable_i && asd_en_i && flt |=> shutdown_o)
    else $error("enabled fault did not shut down");
  man_hold_a: assert property (enable_i && asd_en_i && shutdown_event_flag_o && !auto_restart_i && !event_clr_i
    |=> shutdown_event_flag_o)
    else $error("event bit dropped by itself");
  man_clr_a: assert property (enable_i && asd_en_i && shutdown_event_flag_o && !auto_restart_i && event_clr_i
    && !event_set_i && !flt |=> !shutdown_event_flag_o && !shutdown_o)
    else $error("clear did not leave shutdown");
  asd_off_a: assert property (!asd_en_i && !event_set_i |=> !shutdown_event_flag_o)
    else $error("event bit kept with shutdown off");
  auto_rst_a: assert property (enable_i && asd_en_i && auto_restart_i && shutdown_o && !flt && !event_set_i
    && sel && !$past(sel) |=> !shutdown_o && !shutdown_event_flag_o)
    else $error("no restart on rising source");
  ovr_a_a: assert property (shutdown_o && $past(enable_i) |-> out_a_o == ($past(ovr_a_i) == OVR_HIGH)
    && out_a_oe_o == ($past(ovr_a_i) != OVR_HIZ))
    else $error("primary pin not at override");
  // only a tick in the rising cycle lets the complement drop at once
  dead_b_a: assert property (enable_i && !shutdown_o && !pol_b_i && oe_b_i && sel && !$past(sel)
    && clk_sel_i == CLK_FAST |-> ##2 (!out_b_o || shutdown_o))
    else $error("complement did not drop at once");
  osc_keep_a: assert property (clk_sel_i == CLK_DIV || !enable_i |=> !fast_osc_keep_o)
    else $error("oscillator kept without need");
endmodule : cwgsd_top_asserts

bind cwgsd_top cwgsd_top_asserts i_cwgsd_top_asserts (.*);

// ==== verif/cwgsd_stage.sv ====
// far side model: source driver and a power stage with pulled-down gate
`timescale 1ns/1ps
module cwgsd_stage (
  input  wire logic       clk_i,   // clock
  input  wire logic       rst_i,   // reset
  input  wire logic       run_i,   // let the source toggle
  input  wire logic       lvl_i,   // source level when still
  input  wire logic [2:0] half_i,  // half period minus one
  input  wire logic       lvl_a_i, // primary pin level
  input  wire logic       oe_a_i,  // primary pin driven
  output logic            src_o,   // source into the block
  output logic            gate_a_o // gate seen by the stage
);
  logic [2:0] cnt_r; // half period counter
  logic       tog_r; // toggling level while running
  // toggles by non-blocking assignment on the rising edge, so the block sees
  // each change one edge later; a still source follows lvl_i with no race
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_r <= 1'b0;
      cnt_r <= 3'h0;
    end else if (!run_i) begin
      tog_r <= lvl_i;
      cnt_r <= 3'h0;
    end else if (cnt_r >= half_i) begin
      tog_r <= !tog_r;
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  assign src_o = run_i ? tog_r : lvl_i;
  // a released pin is pulled low so the switch stays off
  assign gate_a_o = oe_a_i ? lvl_a_i : 1'b0;
endmodule : cwgsd_stage

// ==== verif/tb.sv ====
// self-checking bench for the wave shutdown block
`timescale 1ns/1ps
module tb;
  import cwgsd_pkg::*;
  localparam int unsigned WIN = 15; // short idle window
  logic clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b1, clk_sel_i = CLK_FAST;
  logic pol_a_i = 1'b0, pol_b_i = 1'b0, oe_a_i = 1'b1, oe_b_i = 1'b1;
  logic asd_en_i = 1'b1, auto_restart_i = 1'b0, event_set_i = 1'b0, event_clr_i = 1'b0;
  logic fault_source0_select_i = 1'b0, fault_source1_select_i = 1'b0;
  logic logic_cell_output_i = 1'b0, fault_pin_input_i = 1'b0, run = 1'b0, lvl = 1'b0, src, gate;
  logic [SRC_N-1:0] src_i, noise = 4'h0;
  logic [SRC_SEL_W-1:0] src_sel_i = 2'h0;
  logic [DB_W-1:0] rise_dly_i = 6'h00, fall_dly_i = 6'h00;
  logic [2:0] half = 3'h3;
  cwgsd_ovr_t ovr_a_i = OVR_LOW, ovr_b_i = OVR_LOW;
  logic out_a_o, out_a_oe_o, out_b_o, out_b_oe_o, shutdown_event_flag_o, shutdown_o, fast_osc_keep_o;
  int err_count = 0;
  int n_compared = 0;
  logic x;
  always #5 clk_i = ~clk_i;
  // selected source comes from the stage, the others are noise
  always_comb begin
    src_i = noise;
    src_i[src_sel_i] = src;
  end
  cwgsd_top #(.WINDOW(WIN)) i_cwgsd_top (.*);
  cwgsd_stage i_cwgsd_stage (.clk_i, .rst_i, .run_i(run), .lvl_i(lvl), .half_i(half),
    .lvl_a_i(out_a_o), .oe_a_i(out_a_oe_o), .src_o(src), .gate_a_o(gate));
  function automatic logic hit(input logic [3:0] m);
    return (m[3] & m[1]) | (m[2] & m[0]);
  endfunction : hit
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // one source edge: the leading output waits d ticks, the other drops at once
  task automatic db_edge(input logic v, input logic [5:0] d);
    int k;
    k = 0;
    lvl = v;
    while ((v ? out_a_o : out_b_o) !== 1'b1 && k < 80) begin
      cyc(1);
      k++;
      if (k == 3) chk("lagging off", 8'h00, 8'(v ? out_b_o : out_a_o));
    end
    // edge tick loads the counter, d ticks counted, one tick sets the wave, then the pin register
    chk("dead band", 8'(d + 3), 8'(k));
    if (k == 80) end_of_test();
    cyc(70);
  endtask : db_edge
  initial begin
    void'($urandom(32'hCA21));
    src_sel_i = 2'($urandom);
    noise = 4'($urandom);
    cyc(5);
    rst_i = 1'b0;
    cyc(70);
    for (int i = 0; i < 3; i++) begin
      rise_dly_i = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
      fall_dly_i = (i == 1) ? 6'h00 : 6'($urandom);
      db_edge(1'b1, rise_dly_i);
      db_edge(1'b0, fall_dly_i);
    end
    $display("dead band test done");
    for (int c = 0; c < 4; c++) begin
      ovr_a_i = 2'(c);
      ovr_b_i = 2'(3 - c);
      event_set_i = 1'b1;
      event_clr_i = 1'b1;
      cyc(1);
      event_set_i = 1'b0;
      event_clr_i = 1'b0;
      chk("event bit", 8'h01, 8'(shutdown_event_flag_o));
      chk("a pin", 8'(ovr_a_i == OVR_HIGH), 8'(out_a_o));
      chk("b driven", 8'(ovr_b_i != OVR_HIZ), 8'(out_b_oe_o));
      chk("stage gate", 8'(ovr_a_i == OVR_HIGH), 8'(gate));
      cyc(8);
      chk("held shut", 8'h01, 8'(shutdown_o));
      event_clr_i = 1'b1;
      cyc(1);
      event_clr_i = 1'b0;
      chk("cleared bit", 8'h00, 8'(shutdown_event_flag_o));
    end
    $display("software shutdown test done");
    for (int m = 0; m < 16; m++) begin
      {fault_source0_select_i, fault_source1_select_i, logic_cell_output_i, fault_pin_input_i} = 4'(m);
      x = hit(4'(m));
      cyc(1);
      chk("fault shut", 8'(x), 8'(shutdown_o));
      event_clr_i = 1'b1;
      cyc(1);
      event_clr_i = 1'b0;
      chk("level hold", 8'(x), 8'(shutdown_o));
      {logic_cell_output_i, fault_pin_input_i} = 2'h0;
      cyc(1);
      event_clr_i = 1'b1;
      cyc(1);
      event_clr_i = 1'b0;
      chk("fault cleared", 8'h00, 8'(shutdown_o));
    end
    fault_pin_input_i = 1'b1;
    cyc(2);
    asd_en_i = 1'b0;
    cyc(2);
    chk("shutdown off", 8'h00, 8'(shutdown_o));
    fault_pin_input_i = 1'b0;
    asd_en_i = 1'b1;
    $display("fault test done");
    auto_restart_i = 1'b1;
    for (int md = 0; md < 2; md++) begin
      event_set_i = (md == 0);
      fault_pin_input_i = (md == 1);
      cyc(2);
      event_set_i = 1'b0;
      fault_pin_input_i = 1'b0;
      cyc(6);
      chk("waits for edge", 8'h01, 8'(shutdown_o));
      lvl = 1'b1;
      cyc(1);
      chk("restarted", 8'h00, 8'({shutdown_o, shutdown_event_flag_o}));
      lvl = 1'b0;
      cyc(70);
    end
    auto_restart_i = 1'b0;
    $display("auto restart test done");
    run = 1'b1;
    half = 3'($urandom);
    cyc(WIN + 5);
    chk("osc kept", 8'h01, 8'(fast_osc_keep_o));
    clk_sel_i = CLK_DIV;
    cyc(2);
    chk("osc divided", 8'h00, 8'(fast_osc_keep_o));
    clk_sel_i = CLK_FAST;
    run = 1'b0;
    cyc(WIN + 10);
    chk("osc idle", 8'h00, 8'(fast_osc_keep_o));
    run = 1'b1;
    enable_i = 1'b0;
    cyc(2);
    chk("disabled pin", 8'h00, 8'({out_a_o, out_a_oe_o, fast_osc_keep_o}));
    enable_i = 1'b1;
    $display("oscillator test done");
    // random soak, judged by the checker
    for (int i = 0; i < 400; i++) begin
      event_set_i = ($urandom % 16 == 0);
      event_clr_i = ($urandom % 4 == 0);
      {fault_source0_select_i, fault_source1_select_i} = 2'($urandom);
      {logic_cell_output_i, fault_pin_input_i} = ($urandom % 8 == 0) ? 2'($urandom) : 2'h0;
      {auto_restart_i, clk_sel_i, oe_a_i} = 3'($urandom);
      {rise_dly_i, fall_dly_i} = 12'($urandom);
      cyc(1);
    end
    // quiet the requests so nothing sets the bit again right after release
    event_set_i = 1'b0;
    event_clr_i = 1'b0;
    {logic_cell_output_i, fault_pin_input_i} = 2'h0;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(1);
    chk("reset bit", 8'(FLAG_RST), 8'(shutdown_event_flag_o));
    chk("reset shut", 8'h00, 8'(shutdown_o));
    $display("random test done");
    end_of_test();
  end
endmodule : tb
